// [clk_gen_regs_pkg.sv]
// Operation
// - writes to unmapped addresses change nothing
// - spi config register: mirrored sdo, lsb, reset
// - readback bit selects active register values
// - 16-bit customer version at two addresses
// - first reference 10-bit divider, two registers
// - second reference 10-bit divider, two registers
// - test divider low bits; spare register reserved
// - code 0x80 updates active; 0xFF ends stream
`default_nettype none
package clk_gen_regs_pkg;
  // address and bank geometry
  localparam int ADDR_W = 12;
  localparam int NREG = 10;
  localparam int SLOT_W = 5;
  // serial frame shape
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int INSTR_RW_BIT = 15;
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RBK = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_CVL = 12'h005;
  localparam logic [ADDR_W-1:0] ADDR_CVH = 12'h006;
  localparam logic [ADDR_W-1:0] ADDR_R1L = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_R1H = 12'h011;
  localparam logic [ADDR_W-1:0] ADDR_R2L = 12'h012;
  localparam logic [ADDR_W-1:0] ADDR_R2H = 12'h013;
  localparam logic [ADDR_W-1:0] ADDR_TST = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_SPR = 12'h015;
  // command port for operation codes
  localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h0fe;
  // storage slot of each register
  localparam int IDX_CFG = 0;
  localparam int IDX_RBK = 1;
  localparam int IDX_CVL = 2;
  localparam int IDX_CVH = 3;
  localparam int IDX_R1L = 4;
  localparam int IDX_R1H = 5;
  localparam int IDX_R2L = 6;
  localparam int IDX_R2H = 7;
  localparam int IDX_TST = 8;
  localparam int IDX_SPR = 9;
  // field positions
  localparam int CFG_SDO_HI = 7;
  localparam int CFG_SDO_LO = 0;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_SRST_HI = 5;
  localparam int CFG_SRST_LO = 2;
  localparam int RBK_ACTIVE = 0;
  localparam int DIV_HI_W = 2;
  localparam int TEST_W = 6;
  // operation codes
  localparam logic [7:0] OP_UPDATE = 8'h80;
  localparam logic [7:0] OP_END = 8'hff;
  // writable bits per slot, slot 9 leftmost
  localparam logic [NREG-1:0][7:0] WR_MASK = {8'h00, 8'h3f, 8'h03, 8'hff,
    8'h03, 8'hff, 8'hff, 8'hff, 8'h01, 8'he7};
  localparam logic [7:0] I2C_CFG_MASK = 8'h24;
  // defaults of every slot
  localparam logic [NREG-1:0][7:0] REG_RST = {NREG{8'h00}};

  // address to {valid, slot}; unmapped gives valid low
  function automatic logic [SLOT_W-1:0] addr_to_slot(
    input logic [ADDR_W-1:0] a);
    logic [SLOT_W-1:0] s;
    s = '0;
    if (a == ADDR_CFG) s = {1'b1, 4'(IDX_CFG)};
    else if (a == ADDR_RBK) s = {1'b1, 4'(IDX_RBK)};
    else if (a == ADDR_CVL) s = {1'b1, 4'(IDX_CVL)};
    else if (a == ADDR_CVH) s = {1'b1, 4'(IDX_CVH)};
    else if (a == ADDR_R1L) s = {1'b1, 4'(IDX_R1L)};
    else if (a == ADDR_R1H) s = {1'b1, 4'(IDX_R1H)};
    else if (a == ADDR_R2L) s = {1'b1, 4'(IDX_R2L)};
    else if (a == ADDR_R2H) s = {1'b1, 4'(IDX_R2H)};
    else if (a == ADDR_TST) s = {1'b1, 4'(IDX_TST)};
    else if (a == ADDR_SPR) s = {1'b1, 4'(IDX_SPR)};
    return s;
  endfunction
endpackage
`default_nettype wire

// [serial_frame.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_frame (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdio_i,
  input wire logic lsb_first_i,
  input wire logic sdo_active_i,
  input wire logic [7:0] rd_data_i,
  output logic [clk_gen_regs_pkg::ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic [clk_gen_regs_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  // frame phases
  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_HALT} frame_state_t;
  // whole state of the serial engine
  typedef struct packed {
    frame_state_t st;       // current phase
    logic sclk;             // last serial clock level
    logic [3:0] cnt;        // bit count in phase
    logic [15:0] sh;        // receive shifter
    logic rd;               // frame is a read
    logic [clk_gen_regs_pkg::ADDR_W-1:0] addr;  // streaming address
    logic [7:0] tx;         // transmit shifter
    logic dout;             // bit on the wire
    logic sdo_oe;           // four-wire drive
    logic sdio_oe;          // three-wire drive
    logic wr;               // write strobe
    logic [clk_gen_regs_pkg::ADDR_W-1:0] waddr; // write address
    logic [7:0] wdata;      // write data
  } frame_t;

  frame_t q, d;
  logic rise, fall;
  logic [15:0] sh_n;
  logic [7:0] byte_n, cur;

  // edge detect, shifting, address stepping
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.sclk = sclk_i;
    rise = sclk_i & ~q.sclk;
    fall = ~sclk_i & q.sclk;
    sh_n = lsb_first_i ? {sdio_i, q.sh[15:1]} : {q.sh[14:0], sdio_i};
    byte_n = lsb_first_i ? sh_n[15:8] : sh_n[7:0];
    cur = (q.cnt == 4'h0) ? rd_data_i : q.tx;
    if (csn_i) begin
      // frame over: restart and release the pins
      d.st = ST_INSTR;
      d.cnt = 4'h0;
      d.sdo_oe = 1'b0;
      d.sdio_oe = 1'b0;
    end else if (rise && q.st != ST_HALT) begin
      d.sh = sh_n;
      d.cnt = q.cnt + 4'h1;
      if (q.st == ST_INSTR && q.cnt == 4'(clk_gen_regs_pkg::INSTR_BITS-1))
      begin
        // instruction complete
        d.st = ST_DATA;
        d.cnt = 4'h0;
        d.rd = sh_n[clk_gen_regs_pkg::INSTR_RW_BIT];
        d.addr = sh_n[clk_gen_regs_pkg::ADDR_W-1:0];
      end else if (q.st == ST_DATA &&
                   q.cnt == 4'(clk_gen_regs_pkg::BYTE_BITS-1)) begin
        // byte complete: step up in lsb-first, down otherwise
        d.cnt = 4'h0;
        d.addr = lsb_first_i ? q.addr + 12'h001 : q.addr - 12'h001;
        if (!q.rd) begin
          d.wr = 1'b1;
          d.waddr = q.addr;
          d.wdata = byte_n;
          if (q.addr == clk_gen_regs_pkg::ADDR_CMD &&
              byte_n == clk_gen_regs_pkg::OP_END) begin
            d.st = ST_HALT;
          end
        end
      end
    end else if (fall && q.st == ST_DATA && q.rd) begin
      // read data launched on the falling edge
      d.dout = lsb_first_i ? cur[0] : cur[7];
      d.tx = lsb_first_i ? {1'b0, cur[7:1]} : {cur[6:0], 1'b0};
      d.sdo_oe = sdo_active_i;
      d.sdio_oe = ~sdo_active_i;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '{st: ST_INSTR, default: '0};
    end else begin
      q <= d;
    end
  end

  assign addr_o = q.addr;
  assign wr_o = q.wr;
  assign wr_addr_o = q.waddr;
  assign wr_data_o = q.wdata;
  assign sdo_o = q.dout;
  assign sdio_o = q.dout;
  assign sdo_oe_o = q.sdo_oe;
  assign sdio_oe_o = q.sdio_oe;

  // no writes after the end-of-data code
  a_halt_no_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    q.st == ST_HALT |=> !q.wr)
    else $error("write strobe after end of data");
  // never both pins driven
  a_pins_exclusive: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i) !(q.sdo_oe && q.sdio_oe))
    else $error("both data pins driven");
endmodule // serial_frame
`default_nettype wire

// [clk_gen_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module clk_gen_regs (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdio_i,
  input wire logic i2c_mode_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic [9:0] ref1_divider_o,
  output logic [9:0] ref2_divider_o,
  output logic [clk_gen_regs_pkg::TEST_W-1:0] test_divider_o,
  output logic [15:0] customer_version_o
);
  // buffered and active copies of the bank
  typedef struct packed {
    logic [clk_gen_regs_pkg::NREG-1:0][7:0] bufr; // written by host
    logic [clk_gen_regs_pkg::NREG-1:0][7:0] act;  // in use
  } bank_t;

  bank_t q, d;
  logic [clk_gen_regs_pkg::ADDR_W-1:0] rd_addr, wr_addr;
  logic wr;
  logic [7:0] wr_data, rd_data, v, m;
  logic [clk_gen_regs_pkg::SLOT_W-1:0] slot_rd, slot_wr;
  logic [3:0] ridx, widx;
  logic srst;

  // serial engine
  serial_frame u_frame (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sclk_i(sclk_i),
    .csn_i(csn_i),
    .sdio_i(sdio_i),
    .lsb_first_i(q.act[clk_gen_regs_pkg::IDX_CFG][clk_gen_regs_pkg::CFG_LSB_LO]),
    .sdo_active_i(q.act[clk_gen_regs_pkg::IDX_CFG][clk_gen_regs_pkg::CFG_SDO_LO]),
    .rd_data_i(rd_data),
    .addr_o(rd_addr),
    .wr_o(wr),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o)
  );

  // read mux and write decode
  always_comb begin
    d = q;
    slot_rd = clk_gen_regs_pkg::addr_to_slot(rd_addr);
    slot_wr = clk_gen_regs_pkg::addr_to_slot(wr_addr);
    ridx = slot_rd[3:0];
    widx = slot_wr[3:0];
    rd_data = 8'h00;
    if (slot_rd[4]) begin
      // select active or buffered copy
      rd_data = q.act[clk_gen_regs_pkg::IDX_RBK][clk_gen_regs_pkg::RBK_ACTIVE]
        ? q.act[ridx] : q.bufr[ridx];
    end
    v = wr_data & clk_gen_regs_pkg::WR_MASK[widx];
    if (widx == 4'(clk_gen_regs_pkg::IDX_CFG) && i2c_mode_i) begin
      v = wr_data & clk_gen_regs_pkg::I2C_CFG_MASK;
    end
    srst = v[clk_gen_regs_pkg::CFG_SRST_HI] | v[clk_gen_regs_pkg::CFG_SRST_LO];
    // mirrored config pairs
    m = 8'h00;
    m[clk_gen_regs_pkg::CFG_SDO_HI] = v[clk_gen_regs_pkg::CFG_SDO_HI] |
                                      v[clk_gen_regs_pkg::CFG_SDO_LO];
    m[clk_gen_regs_pkg::CFG_SDO_LO] = m[clk_gen_regs_pkg::CFG_SDO_HI];
    m[clk_gen_regs_pkg::CFG_LSB_HI] = v[clk_gen_regs_pkg::CFG_LSB_HI] |
                                      v[clk_gen_regs_pkg::CFG_LSB_LO];
    m[clk_gen_regs_pkg::CFG_LSB_LO] = m[clk_gen_regs_pkg::CFG_LSB_HI];
    if (wr) begin
      if (wr_addr == clk_gen_regs_pkg::ADDR_CMD) begin
        // transfer buffered values into use
        if (wr_data == clk_gen_regs_pkg::OP_UPDATE) begin
          d.act = q.bufr;
        end
      end else if (slot_wr[4]) begin
        if (widx == 4'(clk_gen_regs_pkg::IDX_CFG)) begin
          if (srst) begin
            // defaults everywhere; request bits never stored
            d.bufr = clk_gen_regs_pkg::REG_RST;
            d.act = clk_gen_regs_pkg::REG_RST;
          end else begin
            // config takes effect at once
            d.bufr[widx] = m;
            d.act[widx] = m;
          end
        end else if (widx == 4'(clk_gen_regs_pkg::IDX_RBK)) begin
          // readback select takes effect at once
          d.bufr[widx] = v;
          d.act[widx] = v;
        end else begin
          // staged until the update code
          d.bufr[widx] = v;
        end
      end
      // unmapped write: nothing changes
    end
  end

  // bank register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '{bufr: clk_gen_regs_pkg::REG_RST, act: clk_gen_regs_pkg::REG_RST};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the active copy
  assign ref1_divider_o = {q.act[clk_gen_regs_pkg::IDX_R1H]
    [clk_gen_regs_pkg::DIV_HI_W-1:0], q.act[clk_gen_regs_pkg::IDX_R1L]};
  assign ref2_divider_o = {q.act[clk_gen_regs_pkg::IDX_R2H]
    [clk_gen_regs_pkg::DIV_HI_W-1:0], q.act[clk_gen_regs_pkg::IDX_R2L]};
  assign test_divider_o = q.act[clk_gen_regs_pkg::IDX_TST]
    [clk_gen_regs_pkg::TEST_W-1:0];
  assign customer_version_o = {q.act[clk_gen_regs_pkg::IDX_CVH],
    q.act[clk_gen_regs_pkg::IDX_CVL]};

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_unmapped_ignored: assert property (
    wr && !slot_wr[4] && wr_addr != clk_gen_regs_pkg::ADDR_CMD
    |=> q == $past(q))
    else $error("unmapped write changed state");
  a_cfg_mirrored: assert property (
    q.bufr[clk_gen_regs_pkg::IDX_CFG][7:6] ==
    {q.bufr[clk_gen_regs_pkg::IDX_CFG][0], q.bufr[clk_gen_regs_pkg::IDX_CFG][1]})
    else $error("config pairs not mirrored");
  a_i2c_cfg_reset_only: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CFG && i2c_mode_i
    |=> q.bufr[clk_gen_regs_pkg::IDX_CFG] == 8'h00)
    else $error("i2c config kept non reset bits");
  a_readback_active: assert property (
    slot_rd[4] && q.act[clk_gen_regs_pkg::IDX_RBK][0] |-> rd_data == q.act[ridx])
    else $error("readback ignored active select");
  a_version_high: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CVH
    |=> q.bufr[clk_gen_regs_pkg::IDX_CVH] == $past(wr_data))
    else $error("version high byte not stored");
  a_ref1_high_masked: assert property (
    q.bufr[clk_gen_regs_pkg::IDX_R1H][7:2] == 6'h00)
    else $error("first divider reserved bits set");
  a_ref2_low: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_R2L
    |=> q.bufr[clk_gen_regs_pkg::IDX_R2L] == $past(wr_data))
    else $error("second divider low byte not stored");
  a_spare_zero: assert property (
    q.bufr[clk_gen_regs_pkg::IDX_SPR] == 8'h00 &&
    q.bufr[clk_gen_regs_pkg::IDX_TST][7:6] == 2'b00)
    else $error("reserved test bits set");
  a_update_copies: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CMD &&
    wr_data == clk_gen_regs_pkg::OP_UPDATE |=> q.act == $past(q.bufr))
    else $error("update did not copy bank");
  a_soft_reset: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CFG && (wr_data[5] | wr_data[2])
    |=> q.bufr == clk_gen_regs_pkg::REG_RST && q.act == clk_gen_regs_pkg::REG_RST)
    else $error("soft reset did not restore defaults");
  // reserved readback bits never stored
  a_rbk_reserved: assert property (
    q.bufr[clk_gen_regs_pkg::IDX_RBK][7:1] == 7'h00)
    else $error("readback reserved bits set");
  // second divider upper bits stay clear
  a_ref2_high_masked: assert property (
    q.bufr[clk_gen_regs_pkg::IDX_R2H][7:2] == 6'h00)
    else $error("second divider reserved bits set");
  // reset request bits clear themselves
  a_srst_self_clear: assert property (
    !q.bufr[clk_gen_regs_pkg::IDX_CFG][clk_gen_regs_pkg::CFG_SRST_HI] &&
    !q.bufr[clk_gen_regs_pkg::IDX_CFG][clk_gen_regs_pkg::CFG_SRST_LO])
    else $error("soft reset request stayed set");
  // low version byte lands whole
  a_version_low: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CVL
    |=> q.bufr[clk_gen_regs_pkg::IDX_CVL] == $past(wr_data))
    else $error("version low byte not stored");
  // first divider low byte lands whole
  a_ref1_low: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_R1L
    |=> q.bufr[clk_gen_regs_pkg::IDX_R1L] == $past(wr_data))
    else $error("first divider low byte not stored");
  // staged writes never touch the active copy
  a_staged_write: assert property (
    wr && slot_wr[4] && widx > 4'(clk_gen_regs_pkg::IDX_RBK)
    |=> q.act == $past(q.act))
    else $error("staged write reached active copy");
  // config and readback act at once, both copies equal
  a_cfg_immediate: assert property (
    q.act[clk_gen_regs_pkg::IDX_CFG] == q.bufr[clk_gen_regs_pkg::IDX_CFG] &&
    q.act[clk_gen_regs_pkg::IDX_RBK] == q.bufr[clk_gen_regs_pkg::IDX_RBK])
    else $error("config or readback copies differ");
  // unmapped and command reads give zero
  a_unmapped_read_zero: assert property (
    !slot_rd[4] |-> rd_data == 8'h00)
    else $error("unmapped read returned data");
  // spare register never reaches the active copy
  a_spare_act_zero: assert property (
    q.act[clk_gen_regs_pkg::IDX_SPR] == 8'h00)
    else $error("spare register became active");
  // other operation codes leave the bank alone
  a_cmd_other_ignored: assert property (
    wr && wr_addr == clk_gen_regs_pkg::ADDR_CMD &&
    wr_data != clk_gen_regs_pkg::OP_UPDATE |=> q == $past(q))
    else $error("operation code other than update changed bank");

  c_update: cover property (wr && wr_addr == clk_gen_regs_pkg::ADDR_CMD &&
    wr_data == clk_gen_regs_pkg::OP_UPDATE);
  c_soft_reset: cover property (wr && wr_addr == clk_gen_regs_pkg::ADDR_CFG &&
    srst);
  c_read_drive: cover property (sdo_oe_o || sdio_oe_o);
  // lsb-first framing in use, and an ignored write
  c_lsb_mode: cover property (
    q.act[clk_gen_regs_pkg::IDX_CFG][clk_gen_regs_pkg::CFG_LSB_LO]);
  c_unmapped_write: cover property (wr && !slot_wr[4]);
endmodule // clk_gen_regs
`default_nettype wire

// [serial_host.sv]
`timescale 1ns/1ps
`default_nettype none
// serial master model: mode 0 frames, msb or lsb first, slow serial clock
module serial_host (
  input wire logic core_clk_i,
  input wire logic sdio_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  logic dat_q; // bit being sent
  logic idle_q; // pattern shown while the line is released
  // a released line never holds its last value
  always @(posedge core_clk_i) begin
    idle_q <= ~idle_q;
  end
  assign sdio_o = sdio_oe_o ? dat_q : idle_q;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dat_q = 1'b0;
    idle_q = 1'b0;
    sdio_oe_o = 1'b0;
  end
  // one bit: data set, sampled at the rise, three cycles each phase
  task automatic bit_cyc(input logic drv, input logic b, input logic use_sdo,
    output logic s);
    @(posedge core_clk_i);
    sdio_oe_o <= drv;
    dat_q <= b;
    repeat (2) @(posedge core_clk_i);
    s = use_sdo ? sdo_i : sdio_i;
    sclk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sclk_o <= 1'b0;
  endtask
  // whole frame: instruction then bytes; reads fill q in place
  task automatic frame(input logic rd, input logic [11:0] a,
    input logic use_sdo, input logic lsb, ref logic [7:0] q[$]);
    logic [15:0] ins;
    logic s;
    int b;
    ins = {rd, 3'b000, a};
    @(posedge core_clk_i);
    cs_n_o <= 1'b0;
    // bit order follows the device's lsb-first setting
    for (int i = 0; i < 16; i++) begin
      b = lsb ? i : 15 - i;
      bit_cyc(1'b1, ins[b], 1'b0, s);
    end
    foreach (q[k]) begin
      for (int i = 0; i < 8; i++) begin
        b = lsb ? i : 7 - i;
        bit_cyc(!rd, q[k][b], use_sdo, s);
        if (rd) q[k][b] = s;
      end
    end
    repeat (3) @(posedge core_clk_i);
    cs_n_o <= 1'b1;
    sdio_oe_o <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
endmodule // serial_host
`default_nettype wire

// [clk_gen_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module clk_gen_regs_tb;
  logic core_clk_i, rstn_i, i2c_mode_i; // design inputs
  logic sclk, cs_n, host_sdio, host_oe; // host side
  logic dut_sdio, dut_sdio_oe, dut_sdo, dut_sdo_oe; // design pins
  logic [9:0] ref1, ref2; // active dividers
  logic [5:0] tdiv; // active test divider
  logic [15:0] cver; // active version
  logic [7:0] bm [logic [11:0]]; // buffered model
  logic [7:0] am [logic [11:0]]; // active model
  logic [11:0] maps [10] = '{12'h000, 12'h004, 12'h005, 12'h006, 12'h010,
    12'h011, 12'h012, 12'h013, 12'h014, 12'h015};
  int n_errors = 0;
  int checks = 0;
  // wire levels from every party's enable
  wire logic sdio_line = dut_sdio_oe ? dut_sdio : host_sdio;
  wire logic sdo_line = dut_sdo_oe ? dut_sdo : ~host_sdio;
  serial_host serial_host_inst (.core_clk_i(core_clk_i),
    .sdio_i(sdio_line), .sdo_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdio_o(host_sdio), .sdio_oe_o(host_oe));
  clk_gen_regs clk_gen_regs_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .sclk_i(sclk), .csn_i(cs_n), .sdio_i(sdio_line),
    .i2c_mode_i(i2c_mode_i), .sdo_o(dut_sdo), .sdo_oe_o(dut_sdo_oe),
    .sdio_o(dut_sdio), .sdio_oe_o(dut_sdio_oe), .ref1_divider_o(ref1),
    .ref2_divider_o(ref2), .test_divider_o(tdiv),
    .customer_version_o(cver));
  // clock, 4 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // writable bits of each address
  function automatic logic [7:0] wmask(input logic [11:0] a);
    case (a)
      12'h000: return i2c_mode_i ? 8'h24 : 8'he7;
      12'h004: return 8'h01;
      12'h005, 12'h006, 12'h010, 12'h012: return 8'hff;
      12'h011, 12'h013: return 8'h03;
      12'h014: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction
  // random data with reserved bits at their default
  function automatic logic [7:0] rnd(input logic [11:0] a);
    return 8'($urandom) & wmask(a);
  endfunction
  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic model_rst();
    foreach (maps[i]) begin
      bm[maps[i]] = 8'h00;
      am[maps[i]] = 8'h00;
    end
  endtask
  // model of one byte write
  task automatic model_wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] m;
    logic [7:0] r;
    m = d & wmask(a);
    r = {<<{m}};
    if (a == 12'h0fe && d == 8'h80) begin
      foreach (bm[k]) am[k] = bm[k];
    end else if (a == 12'h000 && (m[5] | m[2])) begin
      model_rst();
    end else if (a == 12'h000) begin
      bm[a] = m | r;
      am[a] = bm[a];
    end else if (a == 12'h004) begin
      bm[a] = m;
      am[a] = m;
    end else if (bm.exists(a) && a != 12'h015) begin
      bm[a] = m;
    end
  endtask
  // write frame, address stepping down per byte, up in lsb mode
  task automatic wr(input logic [11:0] a, input logic [7:0] d[$]);
    logic [7:0] q[$];
    logic ended;
    logic lsb;
    logic [11:0] b;
    q = d;
    ended = 1'b0;
    lsb = bm[12'h000][6];
    serial_host_inst.frame(1'b0, a, 1'b0, lsb, q);
    foreach (d[k]) begin
      b = lsb ? a + 12'(k) : a - 12'(k);
      if (!ended) model_wr(b, d[k]);
      if (b == 12'h0fe && d[k] == 8'hff) ended = 1'b1;
    end
  endtask
  // read frame of n bytes, each compared with the model
  task automatic rd(input logic [11:0] a, input int n);
    logic [7:0] q[$];
    logic [11:0] b;
    logic [7:0] e;
    logic lsb;
    q = {};
    repeat (n) q.push_back(8'h00);
    lsb = bm[12'h000][6];
    serial_host_inst.frame(1'b1, a, bm[12'h000][7], lsb, q);
    foreach (q[k]) begin
      b = lsb ? a + 12'(k) : a - 12'(k);
      e = !bm.exists(b) ? 8'h00 : (bm[12'h004][0] ? am[b] : bm[b]);
      chk("rdata", 16'(q[k]), 16'(e));
    end
  endtask
  task automatic chk_outs();
    chk("ref1", 16'(ref1), {6'h00, am[12'h011][1:0], am[12'h010]});
    chk("ref2", 16'(ref2), {6'h00, am[12'h013][1:0], am[12'h012]});
    chk("tdiv", 16'(tdiv), 16'(am[12'h014][5:0]));
    chk("cver", cver, {am[12'h006], am[12'h005]});
  endtask
  task automatic final_report();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hung frame
  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_errors++;
    final_report();
  end
  // main sequence
  initial begin
    rstn_i = 1'b0;
    i2c_mode_i = 1'b0;
    void'($urandom(54));
    model_rst();
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    // defaults, plus an unmapped place
    foreach (maps[i]) rd(maps[i], 1);
    rd(12'h020, 1);
    chk_outs();
    // buffered writes, not active before the update code
    wr(12'h011, {rnd(12'h011), rnd(12'h010)});
    wr(12'h013, {rnd(12'h013), rnd(12'h012)});
    wr(12'h014, {rnd(12'h014)});
    wr(12'h006, {rnd(12'h006), rnd(12'h005)});
    rd(12'h014, 5);
    rd(12'h006, 2);
    chk_outs();
    wr(12'h0fe, {8'h80});
    chk_outs();
    // readback of active copy while buffered differs
    wr(12'h010, {rnd(12'h010) ^ 8'h5a});
    wr(12'h004, {8'h01});
    rd(12'h010, 1);
    rd(12'h004, 1);
    wr(12'h004, {8'h00});
    // unmapped write, end marker stops the frame
    wr(12'h020, {8'h55});
    wr(12'h0fe, {8'hff, 8'h80});
    rd(12'h014, 5);
    chk_outs();
    // mirrored data output enable, read on the four-wire pin, then mirrored lsb-first
    wr(12'h000, {8'h80});
    rd(12'h000, 1);
    wr(12'h000, {8'h02});
    rd(12'h000, 1);
    wr(12'h000, {8'h00});
    // soft reset through bit 2 in spi mode and bit 5 in i2c mode; spare left alone
    for (int md = 0; md < 2; md++) begin
      @(posedge core_clk_i);
      i2c_mode_i <= md[0];
      @(posedge core_clk_i);
      wr(12'h000, {8'hc3});
      rd(12'h000, 1);
      wr(12'h000, {8'h00});
      wr(12'h011, {rnd(12'h011), rnd(12'h010) | 8'h01});
      wr(12'h0fe, {8'h80});
      chk_outs();
      wr(12'h000, {md ? 8'h20 : 8'h04});
      rd(12'h000, 1);
      rd(12'h014, 5);
      chk_outs();
    end
    final_report();
  end
endmodule // clk_gen_regs_tb
`default_nettype wire
